// file: design/fcc_pkg.sv
// Shared constants and types of the fault collection and control block.
package fcc_pkg;
    localparam int NSRC  = 8;
    localparam int NEXT  = 5;
    localparam int AW    = 16;
    localparam int DEPTH = 8;
    localparam int IW    = 3;
    // Fault source positions.
    localparam int SRC_ST = 5;
    localparam int SRC_CE = 6;
    localparam int SRC_UE = 7;
    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_REACT  = 8'h08;
    localparam logic [7:0] OFF_FAKE   = 8'h0c;
    localparam logic [7:0] OFF_INJ    = 8'h10;
    localparam logic [7:0] OFF_KNOWN  = 8'h14;
    localparam logic [7:0] OFF_MIDX   = 8'h18;
    localparam logic [7:0] OFF_MDATA  = 8'h1c;
    // Field positions.
    localparam int CTRL_ENTER = 0;
    localparam int CTRL_LEAVE = 1;
    localparam int CTRL_OVER  = 2;
    localparam int CTRL_NOREA = 3;
    localparam int CTRL_RREQ  = 4;
    localparam int CTRL_STATE = 8;
    localparam int INJ_UE     = 16;
    localparam int ENT_KNOWN  = 16;
    localparam int ENT_UE     = 17;
    localparam int ENT_VLD    = 18;
    // Reaction codes, two bits per source.
    localparam logic [1:0] RX_NONE = 2'h0;
    localparam logic [1:0] RX_IRQ  = 2'h1;
    localparam logic [1:0] RX_FRST = 2'h2;
    localparam logic [1:0] RX_EXT  = 2'h3;
    // Values after reset and counts.
    localparam logic [15:0] REACT_RST   = 16'h0000;
    localparam logic [31:0] CFG_TICKS   = 32'h0001_0000;
    localparam logic [4:0]  REACT_LIMIT = 5'h10;
    localparam logic [1:0]  FOUT_OK     = 2'h1;
    localparam logic [1:0]  FOUT_FAIL   = 2'h2;
    localparam logic [1:0]  FOE_ON      = 2'h3;
    localparam logic [1:0]  FOE_OFF     = 2'h0;

    typedef enum logic [1:0] {ST_NORMAL, ST_CONFIG, ST_FAULT} fcc_state_t;

    typedef struct packed {
        logic          vld;
        logic          ue;
        logic [AW-1:0] addr;
    } fcc_ecc_t;

    typedef struct packed {
        logic          vld;
        logic          ue;
        logic          known;
        logic [AW-1:0] addr;
    } fcc_entry_t;
endpackage

// file: design/fcc_supervisor.sv
// Output supervisor: bounds the configuration state and catches a missing reaction.
`timescale 1ns/1ps
module fcc_supervisor #(
    parameter logic [31:0] CFG_TICKS = fcc_pkg::CFG_TICKS
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Observed collector state
    input  wire logic tick,
    input  wire logic in_cfg,
    input  wire logic need,
    input  wire logic reacted,
    // Findings
    output logic      cfg_over,
    output logic      no_react
);
    logic [31:0] cfg_cnt_q;
    logic [4:0]  rea_cnt_q;

    // Counts oscillator ticks only; there is nothing to configure here.
    always_ff @(posedge clk) begin
        if (reset || !in_cfg) begin
            cfg_cnt_q <= 32'h0;
        end else if (tick && cfg_cnt_q < CFG_TICKS) begin // R6
            cfg_cnt_q <= cfg_cnt_q + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_over <= 1'b0;
        end else if (cfg_cnt_q == CFG_TICKS) begin // R21
            cfg_over <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || !need || reacted) begin
            rea_cnt_q <= 5'h0;
        end else if (rea_cnt_q != fcc_pkg::REACT_LIMIT) begin
            rea_cnt_q <= rea_cnt_q + 5'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            no_react <= 1'b0;
        end else if (rea_cnt_q == fcc_pkg::REACT_LIMIT) begin // R5
            no_react <= 1'b1;
        end
    end

    a_cfg_limit: assert property (@(posedge clk) disable iff (reset) // R6
        cfg_cnt_q <= CFG_TICKS) else $error("config tick count beyond limit");
    a_react_quiet: assert property (@(posedge clk) disable iff (reset) // R5
        (reacted || !need) |=> rea_cnt_q == 5'h0) else $error("reaction timer ran while reacting");
endmodule // fcc_supervisor

// file: design/fcc_mem_table.sv
// Reporting table of recorded memory errors, registered read port and address match.
`timescale 1ns/1ps
module fcc_mem_table (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset,
    // Write port
    input  wire logic                       we,
    input  wire logic [fcc_pkg::IW-1:0]     widx,
    input  wire fcc_pkg::fcc_entry_t        wentry,
    // Read port
    input  wire logic [fcc_pkg::IW-1:0]     ridx,
    output fcc_pkg::fcc_entry_t             rdata_q,
    // Address lookup
    input  wire logic [fcc_pkg::AW-1:0]     maddr,
    output logic                            mhit
);
    fcc_pkg::fcc_entry_t mem_q [fcc_pkg::DEPTH];

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < fcc_pkg::DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (we) begin // R13
            mem_q[widx] <= wentry;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= '0;
        end else begin // R15
            rdata_q <= mem_q[ridx];
        end
    end

    always_comb begin
        mhit = 1'b0;
        for (int i = 0; i < fcc_pkg::DEPTH; i++) begin
            if (mem_q[i].vld && mem_q[i].addr == maddr) begin
                mhit = 1'b1;
            end
        end
    end

    a_table_write: assert property (@(posedge clk) disable iff (reset) // R13
        we |=> mem_q[$past(widx)] == $past(wentry)) else $error("table entry not written");
endmodule // fcc_mem_table

// file: design/fcc_fault_collector.sv
// Fault collector top: bus slave, fault status, reactions and memory error handling.
//
// Function
// R1: Collect every safety mechanism fault and enter the configured safe state.
// R2: Each fault source has its own reaction setting.
// R3: Reactions are none, interrupt, functional reset or external failure pins.
// R4: Collection and reaction need no processor, except the interrupt reaction.
// R5: Supervisor requests reset when the collector fails to react.
// R6: Supervisor is fixed and bounds config state to 10000h oscillator ticks.
// R7: Two failure output pins report critical failures off chip.
// R8: Failure pins are undriven while in reset.
// R9: Reaction settings change only in config state; other writes are ignored.
// R10: External monitor watches failure pins and holds system safe in time.
// R11: Software sets every safety relevant reaction before safe operation.
// R12: Software clears status to leave fault state, limiting repeated clears; the code keeps no limit on clears.
// R13: Memory error manager records each error address and its correctability.
// R14: Report new correctable errors and every uncorrectable error.
// R15: Recorded errors are readable by software through registers.
// R16: Known addresses written by software suppress later correctable reports.
// R17: Software can inject fake faults into the collector paths.
// R18: Software can inject memory ECC errors into the reporting path.
// R19: Self test faults go either to the reset generator or the collector.
// R20: Each source status flag is sticky until software clears it.
// R21: Overlong config state raises a reset request.
`timescale 1ns/1ps
module fcc_fault_collector #(
    parameter logic [31:0] CFG_TICKS = fcc_pkg::CFG_TICKS
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset,
    // Wishbone slave
    input  wire logic                       wb_cyc,
    input  wire logic                       wb_stb,
    input  wire logic                       wb_we,
    input  wire logic [7:0]                 wb_adr,
    input  wire logic [3:0]                 wb_sel,
    input  wire logic [31:0]                wb_dat_w,
    output logic [31:0]                     wb_dat_r,
    output logic                            wb_ack,
    // Fault sources
    input  wire logic [fcc_pkg::NEXT-1:0]   fault_in,
    input  wire logic                       st_fault,
    input  wire logic                       st_to_reset,
    input  wire fcc_pkg::fcc_ecc_t          ecc_in,
    // Internal RC oscillator
    input  wire logic                       osc_in,
    // Reactions
    output logic                            irq,
    output logic                            func_reset,
    output logic                            reset_req,
    output logic [1:0]                      failure_out,
    output logic [1:0]                      failure_oe
);
    localparam int N = fcc_pkg::NSRC;

    fcc_pkg::fcc_state_t state_q;
    fcc_pkg::fcc_ecc_t   inj_q;
    fcc_pkg::fcc_ecc_t   evt_in;
    fcc_pkg::fcc_ecc_t   evt_q;
    fcc_pkg::fcc_entry_t ent_w;
    fcc_pkg::fcc_entry_t ent_r;

    logic [N-1:0]   status_q, set_v, clr_v, fake_q;
    logic [N-1:0]   irq_m, frst_m, ext_m, any_m;
    logic [2*N-1:0] react_q;
    logic [31:0]    bm, wd, rd_d, dat_q;
    logic [7:0]     adr;
    logic           req, wr, ack_q;
    logic           irq_q, fail_q, frst_q, rreq_q, reacted_q;
    logic [1:0]     fout_q, foe_q;
    logic           osc_s1_q, osc_s2_q, osc_s3_q, osc_lvl_q, tick;
    logic           need, fr_new, cfg_over, no_react, mhit, st_rst;
    logic           hw_we, kn_wr, tbl_we;
    logic [2:0]     wptr_q, ridx_q;

    // Bus decode.
    assign adr = {wb_adr[7:2], 2'b00};
    assign req = wb_cyc && wb_stb;
    // A write lands at the edge where the master samples ack.
    assign wr  = req && wb_we && ack_q;
    assign bm  = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};
    assign wd  = wb_dat_w & bm;
    assign clr_v = (wr && adr == fcc_pkg::OFF_STATUS) ? wd[N-1:0] : '0;
    assign kn_wr = wr && adr == fcc_pkg::OFF_KNOWN;

    // Known address writes wait while a memory error is about to be recorded,
    // so the table never sees two writers in one cycle.
    always_ff @(posedge clk) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q &&
                     !(wb_we && adr == fcc_pkg::OFF_KNOWN && evt_in.vld);
        end
    end

    always_comb begin
        rd_d = 32'h0;
        case (adr)
            fcc_pkg::OFF_CTRL: begin
                rd_d[fcc_pkg::CTRL_OVER]  = cfg_over;
                rd_d[fcc_pkg::CTRL_NOREA] = no_react;
                rd_d[fcc_pkg::CTRL_RREQ]  = rreq_q;
                rd_d[fcc_pkg::CTRL_STATE +: 2] = state_q;
            end
            fcc_pkg::OFF_STATUS: rd_d[N-1:0] = status_q;
            fcc_pkg::OFF_REACT: rd_d[2*N-1:0] = react_q;
            fcc_pkg::OFF_MIDX: rd_d[2:0] = ridx_q;
            fcc_pkg::OFF_MDATA: rd_d[fcc_pkg::ENT_VLD:0] = ent_r; // R15
            default: rd_d = 32'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            dat_q <= 32'h0;
        end else if (req && !ack_q) begin
            dat_q <= rd_d;
        end
    end

    // Oscillator input crosses into the clock domain through three stages.
    always_ff @(posedge clk) begin
        if (reset) begin
            osc_s1_q  <= 1'b0;
            osc_s2_q  <= 1'b0;
            osc_s3_q  <= 1'b0;
            osc_lvl_q <= 1'b0;
        end else begin
            osc_s1_q <= osc_in;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
            if (osc_s2_q == osc_s3_q) begin
                osc_lvl_q <= osc_s3_q;
            end
        end
    end

    assign tick = osc_s2_q && osc_s3_q && !osc_lvl_q;

    // Reaction settings only move in config state.
    always_ff @(posedge clk) begin
        if (reset) begin
            react_q <= fcc_pkg::REACT_RST;
        end else if (wr && adr == fcc_pkg::OFF_REACT &&
                     state_q == fcc_pkg::ST_CONFIG) begin // R9
            react_q <= (react_q & ~bm[2*N-1:0]) | wd[2*N-1:0]; // R2
        end
    end

    always_comb begin
        for (int i = 0; i < N; i++) begin
            irq_m[i]  = react_q[2*i +: 2] == fcc_pkg::RX_IRQ; // R3
            frst_m[i] = react_q[2*i +: 2] == fcc_pkg::RX_FRST;
            ext_m[i]  = react_q[2*i +: 2] == fcc_pkg::RX_EXT;
            any_m[i]  = react_q[2*i +: 2] != fcc_pkg::RX_NONE;
        end
    end

    // Fake faults and injected ECC errors enter exactly where real ones do.
    always_ff @(posedge clk) begin
        if (reset) begin
            fake_q <= '0;
            inj_q  <= '0;
        end else begin
            fake_q <= (wr && adr == fcc_pkg::OFF_FAKE) ? wd[N-1:0] : '0; // R17
            inj_q.vld  <= wr && adr == fcc_pkg::OFF_INJ; // R18
            inj_q.ue   <= wd[fcc_pkg::INJ_UE];
            inj_q.addr <= wd[fcc_pkg::AW-1:0];
        end
    end

    assign evt_in = inj_q.vld ? inj_q : ecc_in;

    always_ff @(posedge clk) begin
        if (reset) begin
            evt_q <= '0;
        end else begin
            evt_q <= evt_in;
        end
    end

    // Memory error recording: unknown addresses take the next slot, oldest first.
    assign hw_we  = evt_q.vld && !mhit; // R13
    assign tbl_we = hw_we || kn_wr;

    always_comb begin
        ent_w = '0;
        if (hw_we) begin
            ent_w.vld  = 1'b1;
            ent_w.ue   = evt_q.ue;
            ent_w.addr = evt_q.addr;
        end else begin
            ent_w.vld   = 1'b1; // R16
            ent_w.known = 1'b1;
            ent_w.addr  = wd[fcc_pkg::AW-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wptr_q <= 3'h0;
        end else if (tbl_we) begin
            wptr_q <= wptr_q + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ridx_q <= 3'h0;
        end else if (wr && adr == fcc_pkg::OFF_MIDX) begin
            ridx_q <= wd[2:0];
        end
    end

    fcc_mem_table u_table (
        .clk    (clk),
        .reset  (reset),
        .we     (tbl_we),
        .widx   (wptr_q),
        .wentry (ent_w),
        .ridx   (ridx_q),
        .rdata_q(ent_r),
        .maddr  (evt_q.addr),
        .mhit   (mhit)
    );

    // Fault sources; nothing here waits on software.
    always_comb begin
        set_v = fake_q; // R4
        set_v[fcc_pkg::NEXT-1:0] = set_v[fcc_pkg::NEXT-1:0] | fault_in; // R1
        set_v[fcc_pkg::SRC_ST] = fake_q[fcc_pkg::SRC_ST] || (st_fault && !st_to_reset); // R19
        set_v[fcc_pkg::SRC_CE] = fake_q[fcc_pkg::SRC_CE] ||
                                 (evt_q.vld && !evt_q.ue && !mhit); // R14
        set_v[fcc_pkg::SRC_UE] = fake_q[fcc_pkg::SRC_UE] || (evt_q.vld && evt_q.ue); // R14
    end

    // A fault arriving in the same cycle as its clear stays set.
    always_ff @(posedge clk) begin
        if (reset) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~clr_v) | set_v; // R20
        end
    end

    assign need   = |(status_q & any_m);
    assign fr_new = |(set_v & ~status_q & frst_m);
    assign st_rst = st_fault && st_to_reset;

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= fcc_pkg::ST_NORMAL;
        end else begin
            case (state_q)
                fcc_pkg::ST_NORMAL, fcc_pkg::ST_FAULT: begin
                    if (wr && adr == fcc_pkg::OFF_CTRL && wd[fcc_pkg::CTRL_ENTER]) begin
                        state_q <= fcc_pkg::ST_CONFIG;
                    end else if (need) begin // R1
                        state_q <= fcc_pkg::ST_FAULT;
                    end else begin // R12
                        state_q <= fcc_pkg::ST_NORMAL;
                    end
                end
                fcc_pkg::ST_CONFIG: begin
                    if (cfg_over || (wr && adr == fcc_pkg::OFF_CTRL &&
                                     wd[fcc_pkg::CTRL_LEAVE])) begin
                        state_q <= need ? fcc_pkg::ST_FAULT : fcc_pkg::ST_NORMAL;
                    end
                end
                default: state_q <= fcc_pkg::ST_NORMAL;
            endcase
        end
    end

    // Interrupt and failure reactions follow the sticky flags, so they outlast the source; functional reset pulses once per new fault.
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_q  <= 1'b0;
            fail_q <= 1'b0;
            frst_q <= 1'b0;
        end else begin
            irq_q  <= |(status_q & irq_m); // R3
            fail_q <= |(status_q & ext_m);
            frst_q <= fr_new;
        end
    end

    // Dual rail failure pair: a stuck pin cannot look like the healthy pattern.
    always_ff @(posedge clk) begin
        if (reset) begin
            fout_q <= fcc_pkg::FOUT_OK;
            foe_q  <= fcc_pkg::FOE_OFF; // R8
        end else begin
            fout_q <= (|(status_q & ext_m)) ? fcc_pkg::FOUT_FAIL : fcc_pkg::FOUT_OK; // R7
            foe_q  <= fcc_pkg::FOE_ON;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || !need) begin
            reacted_q <= 1'b0;
        end else if (irq_q || fail_q || frst_q) begin
            reacted_q <= 1'b1;
        end
    end

    fcc_supervisor #(
        .CFG_TICKS(CFG_TICKS)
    ) u_supv (
        .clk     (clk),
        .reset   (reset),
        .tick    (tick),
        .in_cfg  (state_q == fcc_pkg::ST_CONFIG),
        .need    (need),
        .reacted (reacted_q),
        .cfg_over(cfg_over),
        .no_react(no_react)
    );

    // The request holds until the reset generator resets the block.
    always_ff @(posedge clk) begin
        if (reset) begin
            rreq_q <= 1'b0;
        end else if (cfg_over || no_react || st_rst) begin // R5 R19 R21
            rreq_q <= 1'b1;
        end
    end

    assign wb_ack      = ack_q;
    assign wb_dat_r    = dat_q;
    assign irq         = irq_q;
    assign func_reset  = frst_q;
    assign reset_req   = rreq_q;
    assign failure_out = fout_q;
    assign failure_oe  = foe_q;

    a_cfg_gate: assert property (@(posedge clk) disable iff (reset) // R9
        (wr && adr == fcc_pkg::OFF_REACT && state_q != fcc_pkg::ST_CONFIG) |=> $stable(react_q))
        else $error("reaction written outside config");
    a_flag_sticky: assert property (@(posedge clk) disable iff (reset) // R20
        (clr_v == '0) |=> (status_q & $past(status_q)) == $past(status_q))
        else $error("status flag lost without clear");
    a_set_wins: assert property (@(posedge clk) disable iff (reset) // R20
        1'b1 |=> (status_q & $past(set_v)) == $past(set_v))
        else $error("fault event dropped");
    a_irq_follow: assert property (@(posedge clk) disable iff (reset) // R3
        |(status_q & irq_m) |=> irq_q) else $error("interrupt reaction missing");
    a_fail_pins: assert property (@(posedge clk) disable iff (reset) // R7
        |(status_q & ext_m) |=> fout_q == fcc_pkg::FOUT_FAIL) else $error("failure pins not set");
    a_pins_off_reset: assert property (@(posedge clk) // R8
        $past(reset) |-> foe_q == fcc_pkg::FOE_OFF) else $error("failure pins driven in reset");
    a_ue_report: assert property (@(posedge clk) disable iff (reset) // R14
        (evt_q.vld && evt_q.ue) |=> status_q[fcc_pkg::SRC_UE]) else $error("uncorrectable not reported");
    a_frst_cause: assert property (@(posedge clk) disable iff (reset) // R3
        frst_q |-> $past(fr_new)) else $error("functional reset without new fault");
    a_st_route: assert property (@(posedge clk) disable iff (reset) // R19
        st_rst |=> rreq_q) else $error("self test fault did not request reset");
    a_cfg_over_rst: assert property (@(posedge clk) disable iff (reset) // R21
        (state_q == fcc_pkg::ST_CONFIG && cfg_over) |=> rreq_q ##0 state_q != fcc_pkg::ST_CONFIG)
        else $error("config overrun not handled");

    c_config: cover property (@(posedge clk) disable iff (reset) state_q == fcc_pkg::ST_CONFIG);
    c_ext_fail: cover property (@(posedge clk) disable iff (reset) fout_q == fcc_pkg::FOUT_FAIL);
    c_ce_known: cover property (@(posedge clk) disable iff (reset) evt_q.vld && !evt_q.ue && mhit);
    c_cfg_over: cover property (@(posedge clk) disable iff (reset) cfg_over);
endmodule // fcc_fault_collector

// file: verification/fcc_safety_monitor.sv
// External safety monitor model that watches the two failure pins from the board side.
`timescale 1ns/1ps
module fcc_safety_monitor (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Failure pins
    input  wire logic [1:0] failure_out,
    input  wire logic [1:0] failure_oe,
    // System safe state
    output logic            safe_q
);
    logic [1:0] pin_lvl;
    // Undriven pins are pulled low, so a device held in reset is not taken for a failure.
    assign pin_lvl = failure_out & failure_oe;
    always_ff @(posedge clk) begin
        if (reset) begin
            safe_q <= 1'b0;
        end else if (pin_lvl == fcc_pkg::FOUT_FAIL) begin
            safe_q <= 1'b1;
        end
    end
endmodule // fcc_safety_monitor

// file: verification/fault_collection_control_tb_top.sv
// Self-checking testbench of the fault collector with the external monitor attached.
`timescale 1ns/1ps
module fault_collection_control_tb_top;
    localparam logic [31:0] TICKS = 32'h8;
    logic clk = 1'b0, reset = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'hf;
    logic [31:0] wb_dat_w = 32'h0, wb_dat_r, r;
    logic wb_ack, irq, func_reset, reset_req, safe_q;
    logic [7:0] fr_cnt = 8'h0, fr_base;
    logic [4:0] fault_in = 5'h00;
    logic st_fault = 1'b0, st_to_reset = 1'b0, osc_in = 1'b0;
    logic [2:0] oc = 3'h0, e;
    logic [1:0] failure_out, failure_oe;
    logic [15:0] a, react;
    fcc_pkg::fcc_ecc_t ecc_in = '0;
    int errors = 0, checks = 0;

    fcc_fault_collector #(.CFG_TICKS(TICKS)) u_fcc_fault_collector (.clk(clk), .reset(reset),
        .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .fault_in(fault_in),
        .st_fault(st_fault), .st_to_reset(st_to_reset), .ecc_in(ecc_in), .osc_in(osc_in), .irq(irq),
        .func_reset(func_reset), .reset_req(reset_req), .failure_out(failure_out), .failure_oe(failure_oe));
    fcc_safety_monitor u_fcc_safety_monitor (.clk(clk), .reset(reset), .failure_out(failure_out),
        .failure_oe(failure_oe), .safe_q(safe_q));

    always #5 clk = ~clk;
    // The oscillator ticks every 16 clocks so the bus sequences fit inside the config limit.
    always @(posedge clk) begin
        oc <= oc + 3'h1;
        if (oc == 3'h7) osc_in <= ~osc_in;
        if (func_reset === 1'b1) fr_cnt <= fr_cnt + 8'h1;
    end

    task automatic print_verdict;
        if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} <= {2'h3, w, ad, d};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        r = wb_dat_r;
        if (n >= 20) begin
            errors++;
            print_verdict();
        end
        {wb_cyc, wb_stb} <= 2'h0;
        @(posedge clk);
    endtask

    // Expected reactions of one source code: {external, functional reset, interrupt}.
    function automatic logic [2:0] exp_rx(input logic [1:0] code);
        return {code == fcc_pkg::RX_EXT, code == fcc_pkg::RX_FRST, code == fcc_pkg::RX_IRQ};
    endfunction

    task automatic stat(input logic [7:0] x);
        wb(0, fcc_pkg::OFF_STATUS, 32'h0);
        chk("status", {24'h0, x}, r);
        wb(1, fcc_pkg::OFF_STATUS, 32'hff);
    endtask

    task automatic ecc(input logic u, input logic [15:0] ad);
        @(posedge clk) ecc_in <= {1'b1, u, ad};
        @(posedge clk) ecc_in <= '0;
        repeat (4) @(posedge clk);
    endtask

    task automatic rst;
        reset <= 1'b1;
        repeat (6) @(posedge clk);
        chk("oe_in_reset", {30'h0, fcc_pkg::FOE_OFF}, {30'h0, failure_oe});
        reset <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    initial begin
        void'($urandom(32'h74fbf6c7));
        rst();
        chk("oe", {30'h0, fcc_pkg::FOE_ON}, {30'h0, failure_oe});
        wb(1, fcc_pkg::OFF_REACT, 32'hffff);
        wb(0, fcc_pkg::OFF_REACT, 32'h0);
        chk("react_locked", 32'h0, r);
        wb(0, 8'h20, 32'h0);
        chk("unmapped", 32'h0, r);
        react = 16'hfce4;
        wb(1, fcc_pkg::OFF_CTRL, 32'h1);
        wb(1, fcc_pkg::OFF_REACT, {16'h0, react});
        wb(0, fcc_pkg::OFF_REACT, 32'h0);
        chk("react", {16'h0, react}, r);
        wb(1, fcc_pkg::OFF_CTRL, 32'h2);
        for (int i = 0; i < 4; i++) begin
            fr_base = fr_cnt;
            @(posedge clk) fault_in <= 5'h01 << i;
            @(posedge clk) fault_in <= 5'h00;
            repeat (4) @(posedge clk);
            e = exp_rx(react[2*i+:2]);
            chk("irq", {31'h0, e[0]}, {31'h0, irq});
            chk("func_reset", {31'h0, e[1]}, {24'h0, fr_cnt - fr_base});
            chk("fail_pins", {30'h0, e[2] ? fcc_pkg::FOUT_FAIL : fcc_pkg::FOUT_OK}, {30'h0, failure_out});
            stat(8'h01 << i);
        end
        chk("monitor", 32'h1, {31'h0, safe_q});
        a = 16'($urandom);
        wb(1, fcc_pkg::OFF_FAKE, {27'h0, a[4:0]});
        repeat (3) @(posedge clk);
        stat({3'h0, a[4:0]});
        ecc(0, a);
        stat(8'h40);
        ecc(0, a);
        stat(8'h00);
        ecc(1, a);
        stat(8'h80);
        wb(1, fcc_pkg::OFF_MIDX, 32'h0);
        wb(0, fcc_pkg::OFF_MDATA, 32'h0);
        chk("table", (32'h1 << fcc_pkg::ENT_VLD) | {16'h0, a}, r);
        wb(1, fcc_pkg::OFF_INJ, {15'h0, 1'b1, a + 16'h1});
        repeat (4) @(posedge clk);
        stat(8'h80);
        wb(1, fcc_pkg::OFF_KNOWN, {16'h0, a + 16'h2});
        ecc(0, a + 16'h2);
        stat(8'h00);
        @(posedge clk) st_fault <= 1'b1;
        @(posedge clk) st_fault <= 1'b0;
        repeat (4) @(posedge clk);
        stat(8'h20);
        chk("no_reset_req", 32'h0, {31'h0, reset_req});
        {st_fault, st_to_reset} <= 2'h3;
        @(posedge clk) st_fault <= 1'b0;
        repeat (4) @(posedge clk);
        chk("st_reset_req", 32'h1, {31'h0, reset_req});
        rst();
        wb(1, fcc_pkg::OFF_CTRL, 32'h1);
        repeat (200) @(posedge clk);
        wb(0, fcc_pkg::OFF_CTRL, 32'h0);
        chk("cfg_over", 32'h1 << fcc_pkg::CTRL_OVER, r & ((32'h1 << fcc_pkg::CTRL_OVER) | (32'h3 << fcc_pkg::CTRL_STATE)));
        chk("over_reset_req", 32'h1, {31'h0, reset_req});
        print_verdict();
    end
endmodule // fault_collection_control_tb_top
